// >>> logic/rfm_pkg.sv
// Constants of the rail fault and power-good tree mask block
// Behaviour
// - Fault-mask bit 4 ignores linear_reg_a_one faults
// - Fault-mask bit 3 ignores termination regulator faults
// - Fault-mask bit 2 ignores load_switch_b_two faults
// - Fault-mask bit 1 ignores load_switch_b_one faults
// - Fault-mask bit 0 ignores linear_reg_a_three faults
// - Low tree bit 7 drops linear_reg_a_two good
// - Low tree bit 6 drops load_switch_a_one good
// - Low tree bits 5..0 drop converter six..one
// - High bits 7..4 drop control inputs 5,4,2,1
// - High tree bit 3 drops termination regulator good
// - High tree bit 2 drops shared_rail_b_two good
// - High tree bit 1 drops load_switch_b_one good
// - High tree bit 0 drops linear_reg_a_three good
`default_nettype none
package rfm_pkg;
  localparam logic [7:0] ADDR_FAULT_MASK_SECOND = 8'ha3;
  localparam logic [7:0] ADDR_TREE_MASK_LO = 8'ha4;
  localparam logic [7:0] ADDR_TREE_MASK_HI = 8'ha5;
  localparam logic [7:0] RST_FAULT_MASK_SECOND = 8'h20;
  localparam logic [7:0] RST_TREE_MASK_LO = 8'hff;
  localparam logic [7:0] RST_TREE_MASK_HI = 8'hff;
  localparam logic [7:0] FAULT_MASK_WR_BITS = 8'h7f;
  localparam int FAULT_MASKED_RAILS = 5;
  localparam int TREE_MEMBERS = 16;
  localparam int BIT_RES_ZERO = 6;
  localparam int BIT_RES_ONE = 5;
endpackage : rfm_pkg
`default_nettype wire

// >>> logic/rfm_tree_and.sv
// Masked AND of the power-good tree members
`timescale 1ns/100ps
`default_nettype none
module rfm_tree_and #(
  parameter int N = 16
) (
  input wire logic [N-1:0] member_good,
  input wire logic [N-1:0] member_drop,
  output logic all_good
);
  logic [N-1:0] pass;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_mem
      assign pass[i] = member_drop[i] | member_good[i];
    end
  endgenerate
  assign all_good = &pass;
endmodule // rfm_tree_and
`default_nettype wire

// >>> logic/rfm_mask_top.sv
// Second fault mask and first output pin power-good tree masks
`timescale 1ns/100ps
`default_nettype none
module rfm_mask_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] converter_good,
  input wire logic lin_a_two_good,
  input wire logic switch_a_one_good,
  input wire logic lin_a_three_good,
  input wire logic switch_b_one_good,
  input wire logic shared_b_two_good,
  input wire logic termination_good,
  input wire logic [3:0] control_input_state,
  input wire logic [4:0] rail_fault,
  output logic pg_output_pin_one,
  output logic shutdown_req
);
  logic [7:0] fmask_q, fmask_d;
  logic [7:0] tlo_q, tlo_d;
  logic [7:0] thi_q, thi_d;
  logic [7:0] rdata_q, rdata_d;
  logic pg_q, pg_d;
  logic sd_q, sd_d;
  logic [15:0] members;
  logic [15:0] drops;
  logic tree_good;
  logic [4:0] fault_ignore;

  // Bit 7 of the fault mask is read-only zero
  always_comb begin
    fmask_d = fmask_q;
    tlo_d = tlo_q;
    thi_d = thi_q;
    if (reg_wr) begin
      case (reg_addr)
        rfm_pkg::ADDR_FAULT_MASK_SECOND: begin
          fmask_d = reg_wdata & rfm_pkg::FAULT_MASK_WR_BITS;
        end
        rfm_pkg::ADDR_TREE_MASK_LO: begin
          tlo_d = reg_wdata;
        end
        rfm_pkg::ADDR_TREE_MASK_HI: begin
          thi_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        rfm_pkg::ADDR_FAULT_MASK_SECOND: rdata_d = fmask_q;
        rfm_pkg::ADDR_TREE_MASK_LO: rdata_d = tlo_q;
        rfm_pkg::ADDR_TREE_MASK_HI: rdata_d = thi_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Tree member order matches low then high mask bits
  assign members = {control_input_state, termination_good,
                    shared_b_two_good, switch_b_one_good, lin_a_three_good,
                    lin_a_two_good, switch_a_one_good, converter_good};
  assign drops = {thi_q, tlo_q};

  // High bits: 3 termination, 2 shared b two, 1 switch b one, 0 lin a three
  rfm_tree_and #(.N(rfm_pkg::TREE_MEMBERS)) u_tree (
    .member_good(members),
    .member_drop(drops),
    .all_good(tree_good)
  );

  // Bits 4..0: lin a one, termination, switch b two, switch b one, lin a three
  assign fault_ignore = fmask_q[4:0];
  always_comb begin
    pg_d = tree_good;
    sd_d = |(rail_fault & ~fault_ignore);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fmask_q <= rfm_pkg::RST_FAULT_MASK_SECOND;
      tlo_q <= rfm_pkg::RST_TREE_MASK_LO;
      thi_q <= rfm_pkg::RST_TREE_MASK_HI;
      rdata_q <= 8'h00;
      pg_q <= 1'b0;
      sd_q <= 1'b0;
    end else begin
      fmask_q <= fmask_d;
      tlo_q <= tlo_d;
      thi_q <= thi_d;
      rdata_q <= rdata_d;
      pg_q <= pg_d;
      sd_q <= sd_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pg_output_pin_one = pg_q;
  assign shutdown_req = sd_q;

  property p_fault_shutdown;
    @(posedge mclk) disable iff (!rst_b)
    (|(rail_fault & ~fmask_q[4:0])) |=> shutdown_req;
  endproperty
  a_fault_shutdown: assert property (p_fault_shutdown)
    else $error("Unmasked fault gave no shutdown");

  property p_fault_ignored;
    @(posedge mclk) disable iff (!rst_b)
    ((rail_fault & ~fmask_q[4:0]) == 5'h00) |=> !shutdown_req;
  endproperty
  a_fault_ignored: assert property (p_fault_ignored)
    else $error("Masked fault caused shutdown");

  property p_lin_a_one_masked;
    @(posedge mclk) disable iff (!rst_b)
    (fmask_q[4] && rail_fault == 5'h10) |=> !shutdown_req;
  endproperty
  a_lin_a_one_masked: assert property (p_lin_a_one_masked)
    else $error("Masked linear a one fault shut down");

  property p_lin_a_three_live;
    @(posedge mclk) disable iff (!rst_b)
    (!fmask_q[0] && rail_fault[0]) |=> shutdown_req;
  endproperty
  a_lin_a_three_live: assert property (p_lin_a_three_live)
    else $error("Linear a three fault ignored");

  property p_bit7_zero;
    @(posedge mclk) disable iff (!rst_b)
    (reg_rd && reg_addr == rfm_pkg::ADDR_FAULT_MASK_SECOND) |=>
      !reg_rdata[7];
  endproperty
  a_bit7_zero: assert property (p_bit7_zero)
    else $error("Fault mask bit 7 read as one");

  property p_pg_high;
    @(posedge mclk) disable iff (!rst_b)
    (&(members | {thi_q, tlo_q})) |=> pg_output_pin_one;
  endproperty
  a_pg_high: assert property (p_pg_high)
    else $error("Power good low with all members good");

  property p_pg_low;
    @(posedge mclk) disable iff (!rst_b)
    (!(&(members | {thi_q, tlo_q}))) |=> !pg_output_pin_one;
  endproperty
  a_pg_low: assert property (p_pg_low)
    else $error("Power good high with unmasked member bad");

  property p_lin_a_two_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!tlo_q[7] && !lin_a_two_good) |=> !pg_output_pin_one;
  endproperty
  a_lin_a_two_drop: assert property (p_lin_a_two_drop)
    else $error("Linear a two bad yet power good");

  property p_ctl_five_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!thi_q[7] && !control_input_state[3]) |=> !pg_output_pin_one;
  endproperty
  a_ctl_five_drop: assert property (p_ctl_five_drop)
    else $error("Control five low yet power good");

  property p_wr_lo;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == rfm_pkg::ADDR_TREE_MASK_LO) |=>
      tlo_q == $past(reg_wdata);
  endproperty
  a_wr_lo: assert property (p_wr_lo)
    else $error("Low tree mask write lost");

  property p_wr_hi;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == rfm_pkg::ADDR_TREE_MASK_HI) |=>
      thi_q == $past(reg_wdata);
  endproperty
  a_wr_hi: assert property (p_wr_hi)
    else $error("High tree mask write lost");

  property p_wr_fmask;
    @(posedge mclk) disable iff (!rst_b)
    (reg_wr && reg_addr == rfm_pkg::ADDR_FAULT_MASK_SECOND) |=>
      fmask_q == ($past(reg_wdata) & rfm_pkg::FAULT_MASK_WR_BITS);
  endproperty
  a_wr_fmask: assert property (p_wr_fmask)
    else $error("Fault mask write lost");

  property p_term_fault_masked;
    @(posedge mclk) disable iff (!rst_b)
    (fmask_q[3] && rail_fault == 5'h08) |=> !shutdown_req;
  endproperty
  a_term_fault_masked: assert property (p_term_fault_masked)
    else $error("Masked termination fault shut down");

  property p_switch_b_two_live;
    @(posedge mclk) disable iff (!rst_b)
    (!fmask_q[2] && rail_fault[2]) |=> shutdown_req;
  endproperty
  a_switch_b_two_live: assert property (p_switch_b_two_live)
    else $error("Switch b two fault ignored");

  property p_switch_b_one_masked;
    @(posedge mclk) disable iff (!rst_b)
    (fmask_q[1] && rail_fault == 5'h02) |=> !shutdown_req;
  endproperty
  a_switch_b_one_masked: assert property (p_switch_b_one_masked)
    else $error("Masked switch b one fault shut down");

  property p_switch_a_one_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!tlo_q[6] && !switch_a_one_good) |=> !pg_output_pin_one;
  endproperty
  a_switch_a_one_drop: assert property (p_switch_a_one_drop)
    else $error("Switch a one bad yet power good");

  property p_converter_drop;
    @(posedge mclk) disable iff (!rst_b)
    (|(~tlo_q[5:0] & ~converter_good)) |=> !pg_output_pin_one;
  endproperty
  a_converter_drop: assert property (p_converter_drop)
    else $error("Converter bad yet power good");

  property p_term_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!thi_q[3] && !termination_good) |=> !pg_output_pin_one;
  endproperty
  a_term_drop: assert property (p_term_drop)
    else $error("Termination bad yet power good");

  property p_shared_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!thi_q[2] && !shared_b_two_good) |=> !pg_output_pin_one;
  endproperty
  a_shared_drop: assert property (p_shared_drop)
    else $error("Shared rail bad yet power good");

  property p_switch_b_one_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!thi_q[1] && !switch_b_one_good) |=> !pg_output_pin_one;
  endproperty
  a_switch_b_one_drop: assert property (p_switch_b_one_drop)
    else $error("Switch b one bad yet power good");

  property p_lin_a_three_drop;
    @(posedge mclk) disable iff (!rst_b)
    (!thi_q[0] && !lin_a_three_good) |=> !pg_output_pin_one;
  endproperty
  a_lin_a_three_drop: assert property (p_lin_a_three_drop)
    else $error("Linear a three bad yet power good");
endmodule // rfm_mask_top
`default_nettype wire

// >>> testbench/rfm_pg_sampler.sv
// System side model that samples the first power-good pin
`timescale 1ns/100ps
`default_nettype none
module rfm_pg_sampler (
  input wire logic mclk,
  input wire logic pg_pin,
  output logic pg_seen
);
  always_ff @(posedge mclk) begin
    pg_seen <= pg_pin;
  end
endmodule // rfm_pg_sampler
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the fault and power-good tree masks
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk, rst_b, reg_wr, reg_rd, pg, sd, pg_seen, chk, rd_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lo, hi, fm;
  logic [15:0] g;
  logic [4:0] flt;
  logic [1:0] e;
  logic [7:0] rq[$];
  logic [1:0] oq[$];
  int error_cnt, check_count, cyc;
  rfm_mask_top dut (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .converter_good(g[5:0]),
    .switch_a_one_good(g[6]), .lin_a_two_good(g[7]),
    .lin_a_three_good(g[8]), .switch_b_one_good(g[9]),
    .shared_b_two_good(g[10]), .termination_good(g[11]),
    .control_input_state(g[15:12]), .rail_fault(flt),
    .pg_output_pin_one(pg), .shutdown_req(sd));
  rfm_pg_sampler sys (.mclk(mclk), .pg_pin(pg), .pg_seen(pg_seen));
  task automatic end_sim;
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d, input logic [7:0] x);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
    if (r) rq.push_back(x);
    @(posedge mclk);
    #1;
  endtask
  task automatic tree;
    repeat (2) @(posedge mclk);
    #1 chk = 1'b1;
    oq.push_back({&(g | {hi, lo}), |(flt & ~fm[4:0])});
    @(posedge mclk);
    #1 chk = 1'b0;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_q <= reg_rd;
    if (rd_q) cmp(reg_rdata, rq.pop_front());
    if (chk) begin
      e = oq.pop_front();
      cmp({7'h0, pg_seen}, {7'h0, e[1]});
      cmp({7'h0, sd}, {7'h0, e[0]});
    end
    if (cyc > 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, chk, reg_addr, reg_wdata, g, flt} = '0;
    {lo, hi, fm} = {rfm_pkg::RST_TREE_MASK_LO, rfm_pkg::RST_TREE_MASK_HI,
      rfm_pkg::RST_FAULT_MASK_SECOND};
    void'($urandom(32'h9d18));
    repeat (16) @(posedge mclk);
    #1 rst_b = 1'b1;
    bus(0, 1, 8'ha3, 8'h00, fm);
    bus(0, 1, 8'ha4, 8'h00, lo);
    bus(0, 1, 8'ha5, 8'h00, hi);
    bus(1, 1, 8'h66, 8'h12, 8'h00);
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    tree();
    for (int i = 0; i < 48; i++) begin
      {g, flt} = 21'($urandom | $urandom);
      fm = 8'h20 | 8'($urandom & 8'h1f);
      {hi, lo} = (i < 16) ? ~(16'h1 << i) : 16'($urandom);
      bus(1, 0, 8'ha3, fm, 8'h00);
      bus(1, 0, 8'ha4, lo, 8'h00);
      bus(1, 0, 8'ha5, hi, 8'h00);
      bus(0, 1, 8'ha3, 8'h00, fm);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      tree();
    end
    bus(1, 0, 8'ha3, 8'ha0, 8'h00);
    bus(0, 1, 8'ha3, 8'h00, 8'h20);
    for (int r = 0; r < 10; r++) begin
      flt = 5'(5'h1 << (r / 2));
      fm = 8'h20 | ((r % 2) ? {3'h0, flt} : 8'h00);
      bus(1, 0, 8'ha3, fm, 8'h00);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      tree();
    end
    bus(1, 1, 8'ha4, 8'h5a, lo);
    bus(0, 1, 8'ha4, 8'h00, 8'h5a);
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    {lo, hi, fm} = {rfm_pkg::RST_TREE_MASK_LO, rfm_pkg::RST_TREE_MASK_HI,
      rfm_pkg::RST_FAULT_MASK_SECOND};
    bus(0, 1, 8'ha3, 8'h00, fm);
    bus(0, 1, 8'ha4, 8'h00, lo);
    bus(0, 0, 8'h00, 8'h00, 8'h00);
    tree();
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
